// ### src/oag_core.sv
// operand address generation for the 8-bit core
// Behaviour
// - multiply uses A, product to accumulator_pair
// - word divide uses accumulator_pair both ways
// - decimal adjust works on A implicitly
// - digit rotate uses A low nibble
// - registers come from flag-selected bank
// - 3-bit field picks eight, 1-bit two
// - 2-bit field picks one of four pairs
// - byte 11010010 moves R2 into A
// - byte 01000110 increments pair RP2
// - immediates follow opcode, byte or word
// - short direct window FE20h to FF1Fh
// - bit 8 set only for 00h-1Fh
// - window below FF00h is ram, above registers
// - word pairs low then next, start FF1Eh
// - register space FF00h-FFFFh by byte
// - pair-capable special registers accessed as words
// - stack addressed through pointer, 64K space
// - push decrements pointer by two first
// - plain bank drives A16-A19 for direct addresses without prefix, else zero
// - prefixed bank drives A16-A19 for direct addresses under prefix
// - bank number held until rewritten
// - direct address low byte then high
// - codes map R0-R7 and RP0-RP3 in order
`timescale 1ns/1ps
module oag_core import oag_pkg::*; #(
   parameter int BANK_W = OAG_BANK_W,      // extension address width
   parameter int RBANKS = OAG_RBANKS       // register bank count
) (
   input wire logic clock_in,              // core clock
   input wire logic resetn_in,             // sync reset, active low
   input wire logic dec_valid_in,          // instruction present
   input wire oag_class_t op_class_in,     // operand class
   input wire logic [7:0] op_byte0_in,     // opcode byte
   input wire logic [7:0] op_byte1_in,     // first byte after opcode
   input wire logic [7:0] op_byte2_in,     // second byte after opcode
   input wire logic sub_bank_in,           // sub-bank prefix present
   input wire logic bank_select_hi_in,     // bank_select_hi flag
   input wire logic bank_select_lo_in,     // bank_select_lo flag
   input wire logic bank_wr_in,            // bank register write
   input wire logic bank_wr_prefixed_in,   // high: prefixed_bank_register
   input wire logic [BANK_W-1:0] bank_data_in, // bank number
   input wire logic sp_wr_in,              // stack pointer load
   input wire logic [15:0] sp_data_in,     // new stack pointer
   input wire logic reg_wr_in,             // register byte write
   input wire logic [4:0] reg_wr_addr_in,  // bank and register
   input wire logic [7:0] reg_wr_data_in,  // register byte
   output logic op_valid_out,              // operand fields valid
   output logic [4:0] reg_addr_out,        // bank and register code
   output logic reg_word_out,              // register operand is a pair
   output logic reg_dst_acc_out,           // destination is A
   output logic acc_src_out,               // A used implicitly
   output logic acc_pair_out,              // accumulator_pair implicit
   output logic [3:0] digit_mask_out,      // A bits taking part
   output logic [15:0] pair_data_out,      // pair read from bank
   output logic imm_valid_out,             // immediate present
   output logic imm_word_out,              // immediate is 16 bits
   output logic [15:0] imm_out,            // immediate value
   output logic mem_en_out,                // memory operand present
   output logic mem_word_out,              // two-byte memory access
   output logic [15:0] eff_addr_out,       // effective address
   output logic sfr_sel_out,               // address in register space
   output logic range_err_out,             // illegal word start
   output logic [BANK_W-1:0] ext_addr_out, // A16..A19
   output logic [15:0] sp_out,             // stack pointer
   output logic [BANK_W-1:0] plain_bank_out,   // plain_bank_register
   output logic [BANK_W-1:0] prefixed_bank_out // prefixed_bank_register
);
   generate
      if (BANK_W != OAG_BANK_W || RBANKS != OAG_RBANKS) begin : g_chk
         $error("oag_core: bank fields sized for four bits and four banks");
      end
   endgenerate

   // all state in one record
   typedef struct packed {
      logic valid;
      logic [4:0] reg_addr;
      logic reg_word;
      logic dst_acc;
      logic acc_src;
      logic acc_pair;
      logic [3:0] dmask;
      logic imm_valid;
      logic imm_word;
      logic [15:0] imm;
      logic mem_en;
      logic mem_word;
      logic [15:0] ea;
      logic sfr;
      logic rerr;
      logic [3:0] ext;
      logic [15:0] sp;
      logic [3:0] plain_bank;
      logic [3:0] pref_bank;
   } oag_state_t;

   oag_state_t st_q;     // registered state
   oag_state_t st_d;     // next state
   logic [1:0] bank_sel; // current register bank
   logic [15:0] sh_addr; // short/special address
   logic sh_sfr;         // short address in register space
   logic sh_err;         // short word start too high
   logic [7:0] op_b0;    // opcode byte
   logic [2:0] rcode;    // register code picked this cycle

   // glue bank index to a register code
   function automatic logic [4:0] reg_index(input logic [1:0] bank, input logic [2:0] code);
      reg_index = {bank, code};
   endfunction

   assign bank_sel = {bank_select_hi_in, bank_select_lo_in};
   assign op_b0 = op_byte0_in;

   oag_short_map u_map (
      .imm_in(op_byte1_in),
      .sfr_mode_in(op_class_in == OAG_SFR || op_class_in == OAG_SFRP),
      .word_in(op_class_in == OAG_SADDRP || op_class_in == OAG_SFRP),
      .addr_out(sh_addr),
      .sfr_out(sh_sfr),
      .range_err_out(sh_err)
   );

   // the pair holding the chosen register is read one cycle on,
   // so its data line up with the decoded fields
   oag_regfile #(.BANKS(RBANKS)) u_rf (
      .clock_in(clock_in),
      .rd_pair_in({bank_sel, rcode[2:1]}),
      .wr_en_in(reg_wr_in),
      .wr_addr_in(reg_wr_addr_in),
      .wr_data_in(reg_wr_data_in),
      .rd_data_out(pair_data_out)
   );

   // register code for the pair read, from the same decode as below
   always_comb begin
      rcode = op_b0[2:0];
      case (op_class_in)
         OAG_UMUL, OAG_ADJ, OAG_ROT4: rcode = OAG_ACC_IDX;
         OAG_UDIVW: rcode = {OAG_ACC_PAIR, 1'b0};
         OAG_REG1: rcode = OAG_R1_BASE + {2'h0, op_b0[0]};
         OAG_REG16: rcode = {op_b0[1:0], 1'b0};
         default: rcode = op_b0[2:0];
      endcase
   end

   // decode the operand of the instruction now presented
   always_comb begin
      st_d = st_q;
      st_d.valid = dec_valid_in;
      st_d.dst_acc = 1'b0;
      st_d.acc_src = 1'b0;
      st_d.acc_pair = 1'b0;
      st_d.dmask = OAG_NO_MASK;
      st_d.imm_valid = 1'b0;
      st_d.imm_word = 1'b0;
      st_d.imm = 16'h0000;
      st_d.mem_en = 1'b0;
      st_d.mem_word = 1'b0;
      st_d.sfr = 1'b0;
      st_d.rerr = 1'b0;
      st_d.ext = 4'h0;
      st_d.reg_word = 1'b0;
      st_d.reg_addr = reg_index(bank_sel, rcode);
      // bank numbers only move on an explicit write
      if (bank_wr_in && !bank_wr_prefixed_in) begin
         st_d.plain_bank = bank_data_in;
      end
      if (bank_wr_in && bank_wr_prefixed_in) begin
         st_d.pref_bank = bank_data_in;
      end
      if (sp_wr_in) begin
         st_d.sp = sp_data_in;
      end
      if (dec_valid_in) begin
         case (op_class_in)
            OAG_UMUL: begin
               st_d.acc_src = 1'b1;
               st_d.acc_pair = 1'b1;
            end
            OAG_UDIVW: begin
               st_d.acc_pair = 1'b1;
               st_d.reg_word = 1'b1;
            end
            OAG_ADJ: begin
               st_d.acc_src = 1'b1;
            end
            OAG_ROT4: begin
               st_d.acc_src = 1'b1;
               st_d.dmask = OAG_DIGIT_MASK;
            end
            OAG_REG8: begin
               // move-to-A form names the source only
               st_d.dst_acc = (op_b0[7:3] == OAG_MOVA_OP);
            end
            OAG_REG1: begin
               st_d.reg_word = 1'b0;
            end
            OAG_REG16: begin
               st_d.reg_word = 1'b1;
            end
            OAG_IMM8: begin
               st_d.imm_valid = 1'b1;
               st_d.imm = {8'h00, op_byte1_in};
            end
            OAG_IMM16: begin
               st_d.imm_valid = 1'b1;
               st_d.imm_word = 1'b1;
               st_d.imm = {op_byte2_in, op_byte1_in};
            end
            OAG_SADDR, OAG_SADDRP, OAG_SFR, OAG_SFRP: begin
               st_d.mem_en = 1'b1;
               st_d.ea = sh_addr;
               st_d.sfr = sh_sfr;
               st_d.rerr = sh_err;
               // word forms take low byte here, high byte next
               st_d.mem_word = (op_class_in == OAG_SADDRP) || (op_class_in == OAG_SFRP);
            end
            OAG_STACK: begin
               // pointer drops by two before the pair lands
               st_d.mem_en = 1'b1;
               st_d.mem_word = 1'b1;
               st_d.sp = st_q.sp - OAG_SP_STEP;
               st_d.ea = st_q.sp - OAG_SP_STEP;
            end
            OAG_UNSTACK: begin
               st_d.mem_en = 1'b1;
               st_d.mem_word = 1'b1;
               st_d.ea = st_q.sp;
               st_d.sp = st_q.sp + OAG_SP_STEP;
            end
            OAG_DIRECT: begin
               st_d.mem_en = 1'b1;
               st_d.ea = {op_byte2_in, op_byte1_in};
               st_d.sfr = ({op_byte2_in, op_byte1_in} >= OAG_SFR_BASE);
               // prefix swaps in the second bank register
               if (sub_bank_in) begin
                  st_d.ext = st_q.pref_bank;
               end else begin
                  st_d.ext = st_q.plain_bank;
               end
            end
            default: begin
               st_d.reg_addr = st_q.reg_addr;
            end
         endcase
      end
   end

   // single state register; reset clears control, pointer to zero
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         st_q <= '0;
         st_q.sp <= OAG_SP_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign op_valid_out = st_q.valid;
   assign reg_addr_out = st_q.reg_addr;
   assign reg_word_out = st_q.reg_word;
   assign reg_dst_acc_out = st_q.dst_acc;
   assign acc_src_out = st_q.acc_src;
   assign acc_pair_out = st_q.acc_pair;
   assign digit_mask_out = st_q.dmask;
   assign imm_valid_out = st_q.imm_valid;
   assign imm_word_out = st_q.imm_word;
   assign imm_out = st_q.imm;
   assign mem_en_out = st_q.mem_en;
   assign mem_word_out = st_q.mem_word;
   assign eff_addr_out = st_q.ea;
   assign sfr_sel_out = st_q.sfr;
   assign range_err_out = st_q.rerr;
   assign ext_addr_out = st_q.ext;
   assign sp_out = st_q.sp;
   assign plain_bank_out = st_q.plain_bank;
   assign prefixed_bank_out = st_q.pref_bank;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);

   sequence s_take(oag_class_t c);
      dec_valid_in && op_class_in == c;
   endsequence
   // class and opcode byte together, as one boolean
   sequence s_take_op(oag_class_t c, logic [7:0] b);
      dec_valid_in && op_class_in == c && op_byte0_in == b;
   endsequence
   sequence s_push;
      dec_valid_in && op_class_in == OAG_STACK && !sp_wr_in;
   endsequence

   property p_mul;
      s_take(OAG_UMUL) |=> acc_src_out && acc_pair_out && reg_addr_out[2:0] == OAG_ACC_IDX;
   endproperty
   a_mul: assert property (p_mul) else $error("multiply accumulator use wrong");
   property p_div;
      s_take(OAG_UDIVW) |=> acc_pair_out && reg_word_out && reg_addr_out[2:1] == OAG_ACC_PAIR;
   endproperty
   a_div: assert property (p_div) else $error("divide pair use wrong");
   property p_adj;
      s_take(OAG_ADJ) |=> acc_src_out && !acc_pair_out && digit_mask_out == OAG_NO_MASK;
   endproperty
   a_adj: assert property (p_adj) else $error("adjust not on A");
   property p_rot;
      s_take(OAG_ROT4) |=> acc_src_out && digit_mask_out == OAG_DIGIT_MASK;
   endproperty
   a_rot: assert property (p_rot) else $error("rotate mask wrong");
   property p_bank;
      s_take(OAG_REG8) |=> reg_addr_out[4:3] == $past(bank_sel);
   endproperty
   a_bank: assert property (p_bank) else $error("register bank wrong");
   property p_mova;
      s_take_op(OAG_REG8, 8'hd2) |=> reg_dst_acc_out && reg_addr_out[2:0] == 3'h2;
   endproperty
   a_mova: assert property (p_mova) else $error("move to A decode wrong");
   property p_increment_pair;
      s_take_op(OAG_REG16, 8'h46) |=> reg_word_out && reg_addr_out[2:0] == 3'h4;
   endproperty
   a_increment_pair: assert property (p_increment_pair) else $error("pair increment decode wrong");
   property p_saddr;
      s_take(OAG_SADDR) |=> eff_addr_out[15:9] == OAG_SADDR_HI
         && eff_addr_out[8] == ($past(op_byte1_in) < OAG_SADDR_SPLIT)
         && sfr_sel_out == (eff_addr_out >= OAG_SFR_BASE);
   endproperty
   a_saddr: assert property (p_saddr) else $error("short address wrong");
   property p_push;
      s_push |=> sp_out == $past(sp_out) - OAG_SP_STEP && eff_addr_out == sp_out;
   endproperty
   a_push: assert property (p_push) else $error("push pointer step wrong");
   property p_ext;
      s_take(OAG_DIRECT) |=> ext_addr_out == ($past(sub_bank_in) ? $past(prefixed_bank_out)
         : $past(plain_bank_out)) && eff_addr_out == $past({op_byte2_in, op_byte1_in});
   endproperty
   a_ext: assert property (p_ext) else $error("extension address wrong");
   property p_hold;
      !bank_wr_in [*2] |=> $stable(plain_bank_out) && $stable(prefixed_bank_out);
   endproperty
   a_hold: assert property (p_hold) else $error("bank number drifted");
endmodule

// ### src/oag_pkg.sv
// shared constants and types for operand address generation
package oag_pkg;
   // operand class handed over by the opcode decoder
   typedef enum logic [4:0] {
      OAG_NONE,
      OAG_UMUL,      // unsigned_multiply
      OAG_UDIVW,     // unsigned_word_divide
      OAG_ADJ,       // decimal_adjust_after_add / _sub
      OAG_ROT4,      // digit_rotate_right / _left
      OAG_REG8,      // 3-bit register field
      OAG_REG1,      // 1-bit register field
      OAG_REG16,     // 2-bit pair field
      OAG_IMM8,
      OAG_IMM16,
      OAG_SADDR,
      OAG_SADDRP,
      OAG_SFR,
      OAG_SFRP,
      OAG_STACK,     // push side: push, call, context save
      OAG_UNSTACK,   // pop side: pop, return
      OAG_DIRECT     // direct_address_word
   } oag_class_t;
   localparam int OAG_BANK_W = 4;          // extension address width
   localparam int OAG_RBANKS = 4;          // general register banks
   localparam logic [2:0] OAG_ACC_IDX = 3'h1;     // A is R1
   localparam logic [1:0] OAG_ACC_PAIR = 2'h0;    // accumulator_pair is RP0
   localparam logic [2:0] OAG_R1_BASE = 3'h2;     // C=R2, B=R3
   localparam logic [4:0] OAG_MOVA_OP = 5'h1a;    // 11010rrr
   localparam logic [5:0] OAG_INCP_OP = 6'h11;    // 010001pp
   localparam logic [6:0] OAG_SADDR_HI = 7'h7f;   // bits 15..9 of saddr
   localparam logic [7:0] OAG_SADDR_SPLIT = 8'h20;
   localparam logic [7:0] OAG_SFR_HI = 8'hff;
   localparam logic [15:0] OAG_SFR_BASE = 16'hff00;
   localparam logic [15:0] OAG_SADDRP_MAX = 16'hff1e;
   localparam logic [15:0] OAG_SP_STEP = 16'h0002;
   localparam logic [15:0] OAG_SP_RESET = 16'h0000;
   localparam logic [3:0] OAG_DIGIT_MASK = 4'hf;  // low nibble only
   localparam logic [3:0] OAG_NO_MASK = 4'h0;
endpackage

// ### src/oag_regfile.sv
// general register banks: byte writes, registered pair read
`timescale 1ns/1ps
module oag_regfile import oag_pkg::*; #(
   parameter int BANKS = OAG_RBANKS
) (
   input wire logic clock_in,                 // core clock
   input wire logic [$clog2(BANKS)+1:0] rd_pair_in, // bank and pair
   input wire logic wr_en_in,                 // byte write strobe
   input wire logic [$clog2(BANKS)+2:0] wr_addr_in, // bank and register
   input wire logic [7:0] wr_data_in,         // byte to store
   output logic [15:0] rd_data_out            // {high, low} of the pair
);
   localparam int PAIRS = BANKS * 4;
   logic [7:0] lo_mem [PAIRS];   // even registers
   logic [7:0] hi_mem [PAIRS];   // odd registers
   generate
      if (BANKS < 1 || BANKS > 8) begin : g_chk
         $error("oag_regfile: bank count out of range");
      end
   endgenerate
   // contents are data, not control, so they carry no reset
   always_ff @(posedge clock_in) begin
      if (wr_en_in && !wr_addr_in[0]) begin
         lo_mem[wr_addr_in[$clog2(BANKS)+2:1]] <= wr_data_in;
      end
      if (wr_en_in && wr_addr_in[0]) begin
         hi_mem[wr_addr_in[$clog2(BANKS)+2:1]] <= wr_data_in;
      end
      rd_data_out <= {hi_mem[rd_pair_in], lo_mem[rd_pair_in]};
   end
endmodule

// ### src/oag_short_map.sv
// short direct and special register address forming
`timescale 1ns/1ps
module oag_short_map import oag_pkg::*; (
   input wire logic [7:0] imm_in,     // 8-bit operand byte
   input wire logic sfr_mode_in,      // high: special register addressing
   input wire logic word_in,          // high: two-byte access
   output logic [15:0] addr_out,      // effective address
   output logic sfr_out,              // high: lands in register space
   output logic range_err_out         // word start beyond last pair
);
   // window wraps so 00h..1fh lands above the ram part
   always_comb begin
      if (sfr_mode_in) begin
         addr_out = {OAG_SFR_HI, imm_in};
      end else begin
         addr_out = {OAG_SADDR_HI, (imm_in < OAG_SADDR_SPLIT), imm_in};
      end
      sfr_out = (addr_out >= OAG_SFR_BASE);
      range_err_out = word_in && !sfr_mode_in && (addr_out > OAG_SADDRP_MAX);
   end
endmodule

// ### verification/oag_core_tb_top.sv
// self-checking testbench for the operand address generation core
`timescale 1ns/1ps
module oag_core_tb_top;
   import oag_pkg::*;
   logic clock_in, resetn_in, dec_valid_in, sub_bank_in; // clock, reset, decode strobe, prefix
   logic bank_select_hi_in, bank_select_lo_in; // register bank flags
   logic bank_wr_in, bank_wr_prefixed_in, sp_wr_in, reg_wr_in; // write strobes
   oag_class_t op_class_in; // operand class
   logic [7:0] op_byte0_in, op_byte1_in, op_byte2_in, reg_wr_data_in; // instruction bytes
   logic [3:0] bank_data_in; // bank number
   logic [15:0] sp_data_in; // stack pointer load value
   logic [4:0] reg_wr_addr_in; // register write address
   logic op_valid_out, reg_word_out, reg_dst_acc_out, acc_src_out, acc_pair_out;
   logic imm_valid_out, imm_word_out, mem_en_out, mem_word_out, sfr_sel_out, range_err_out;
   logic [4:0] reg_addr_out;
   logic [3:0] digit_mask_out, ext_addr_out, plain_bank_out, prefixed_bank_out;
   logic [15:0] pair_data_out, imm_out, eff_addr_out, sp_out;
   logic [7:0] rf [32]; // bench copy of the register banks
   logic [15:0] sp_m; // expected stack pointer
   logic [3:0] plain_m, pref_m; // expected bank registers
   logic [31:0] seed; // xorshift state
   int n_errors, checks;

   oag_core DUT (.clock_in(clock_in), .resetn_in(resetn_in), .dec_valid_in(dec_valid_in),
      .op_class_in(op_class_in), .op_byte0_in(op_byte0_in), .op_byte1_in(op_byte1_in),
      .op_byte2_in(op_byte2_in), .sub_bank_in(sub_bank_in), .bank_select_hi_in(bank_select_hi_in),
      .bank_select_lo_in(bank_select_lo_in), .bank_wr_in(bank_wr_in),
      .bank_wr_prefixed_in(bank_wr_prefixed_in), .bank_data_in(bank_data_in), .sp_wr_in(sp_wr_in),
      .sp_data_in(sp_data_in), .reg_wr_in(reg_wr_in), .reg_wr_addr_in(reg_wr_addr_in),
      .reg_wr_data_in(reg_wr_data_in), .op_valid_out(op_valid_out), .reg_addr_out(reg_addr_out),
      .reg_word_out(reg_word_out), .reg_dst_acc_out(reg_dst_acc_out), .acc_src_out(acc_src_out),
      .acc_pair_out(acc_pair_out), .digit_mask_out(digit_mask_out), .pair_data_out(pair_data_out),
      .imm_valid_out(imm_valid_out), .imm_word_out(imm_word_out), .imm_out(imm_out),
      .mem_en_out(mem_en_out), .mem_word_out(mem_word_out), .eff_addr_out(eff_addr_out),
      .sfr_sel_out(sfr_sel_out), .range_err_out(range_err_out), .ext_addr_out(ext_addr_out),
      .sp_out(sp_out), .plain_bank_out(plain_bank_out), .prefixed_bank_out(prefixed_bank_out));

   // 200 MHz core clock
   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end

   // repeatable pseudo-random source
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // compare and count; case inequality so unknowns never match
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // closing task shared by the main sequence and the watchdog
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // synchronous reset for four cycles; stack pointer, plain bank and valid outputs must be zero
   task automatic do_reset();
      @(posedge clock_in);
      resetn_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      resetn_in <= 1'b1;
      #1;
      sp_m = 16'h0000;
      plain_m = 4'h0;
      pref_m = 4'h0;
      chk(sp_out, 16'h0000, "sp after reset");
      chk(plain_bank_out, 4'h0, "plain bank after reset");
      chk(op_valid_out, 1'b0, "valid after reset");
   endtask

   // one pulse write: k=0 register byte, k=1 bank register (a[0] picks prefixed), k=2 stack pointer
   task automatic wr(input int k, input logic [15:0] d, input logic [4:0] a);
      @(posedge clock_in);
      case (k)
         0: begin
            reg_wr_in <= 1'b1; reg_wr_addr_in <= a; reg_wr_data_in <= d[7:0]; rf[a] = d[7:0];
         end
         1: begin
            bank_wr_in <= 1'b1; bank_wr_prefixed_in <= a[0]; bank_data_in <= d[3:0];
            if (a[0]) pref_m = d[3:0]; else plain_m = d[3:0];
         end
         default: begin
            sp_wr_in <= 1'b1; sp_data_in <= d; sp_m = d;
         end
      endcase
      @(posedge clock_in);
      reg_wr_in <= 1'b0;
      bank_wr_in <= 1'b0;
      sp_wr_in <= 1'b0;
      #1;
      chk(plain_bank_out, plain_m, "plain bank");
      chk(prefixed_bank_out, pref_m, "prefixed bank");
      chk(sp_out, sp_m, "stack pointer");
   endtask

   // present one instruction with a random register bank and check the answer one cycle on
   task automatic decode(input oag_class_t c, input logic [7:0] b0, b1, b2, input logic sb);
      logic [31:0] r;
      logic [1:0] bk;
      logic [2:0] code;
      logic [15:0] ea;
      r = rnd();
      bk = r[1:0];
      @(posedge clock_in);
      dec_valid_in <= 1'b1; op_class_in <= c; sub_bank_in <= sb;
      op_byte0_in <= b0; op_byte1_in <= b1; op_byte2_in <= b2;
      bank_select_hi_in <= bk[1]; bank_select_lo_in <= bk[0];
      @(posedge clock_in);
      dec_valid_in <= 1'b0;
      #1;
      chk(op_valid_out, 1'b1, "valid");
      chk(ext_addr_out, c == OAG_DIRECT ? (sb ? pref_m : plain_m) : 4'h0, "extension address");
      chk(digit_mask_out, c == OAG_ROT4 ? OAG_DIGIT_MASK : OAG_NO_MASK, "digit mask");
      chk(acc_src_out, c inside {OAG_UMUL, OAG_ADJ, OAG_ROT4}, "implicit A");
      chk(acc_pair_out, c inside {OAG_UMUL, OAG_UDIVW}, "implicit pair");
      chk(imm_valid_out, c inside {OAG_IMM8, OAG_IMM16}, "immediate present");
      chk(mem_en_out, c inside {OAG_SADDR, OAG_SADDRP, OAG_SFR, OAG_SFRP, OAG_STACK, OAG_UNSTACK,
         OAG_DIRECT}, "memory operand");
      case (c)
         OAG_REG8, OAG_REG1, OAG_REG16: begin
            code = c == OAG_REG8 ? b0[2:0] : (c == OAG_REG1 ? {2'b01, b0[0]} : {b0[1:0], 1'b0});
            chk(reg_addr_out, {bk, code}, "register address");
            chk(reg_word_out, c == OAG_REG16, "pair operand");
            chk(reg_dst_acc_out, c == OAG_REG8 && b0[7:3] == 5'h1a, "move into A");
            chk(pair_data_out, {rf[{bk, code[2:1], 1'b1}], rf[{bk, code[2:1], 1'b0}]}, "pair data");
         end
         OAG_IMM8, OAG_IMM16: begin
            chk(imm_word_out, c == OAG_IMM16, "immediate width");
            chk(imm_out, c == OAG_IMM16 ? {b2, b1} : {8'h00, b1}, "immediate value");
         end
         OAG_SADDR, OAG_SADDRP: begin
            ea = {7'h7f, b1 < 8'h20, b1}; // bit 8 set only below 20h
            chk(eff_addr_out, ea, "short direct address");
            chk(sfr_sel_out, ea >= 16'hff00, "short direct target");
            chk(mem_word_out, c == OAG_SADDRP, "short direct width");
            chk(range_err_out, c == OAG_SADDRP && ea > 16'hff1e, "pair start limit");
         end
         OAG_SFR, OAG_SFRP: begin
            chk(eff_addr_out, {8'hff, b1}, "register space address");
            chk(sfr_sel_out, 1'b1, "register space");
            chk(mem_word_out, c == OAG_SFRP, "register width");
         end
         OAG_STACK: begin
            sp_m = sp_m - 16'h0002; // pointer drops by two before the store
            chk(eff_addr_out, sp_m, "push address");
            chk(mem_word_out, 1'b1, "push width");
         end
         OAG_UNSTACK: begin
            chk(eff_addr_out, sp_m, "pop address");
            sp_m = sp_m + 16'h0002;
         end
         OAG_DIRECT: begin
            chk(eff_addr_out, {b2, b1}, "direct address");
            chk(sfr_sel_out, {b2, b1} >= 16'hff00, "direct target");
         end
         default: ;
      endcase
      chk(sp_out, sp_m, "stack pointer");
      chk(plain_bank_out, plain_m, "bank held");
   endtask

   // watchdog: the whole sequence needs about a thousand cycles
   initial begin
      repeat (20000) @(posedge clock_in);
      n_errors++;
      $display("watchdog expired at %0t", $time);
      print_verdict();
   end

   // main sequence
   initial begin
      logic [31:0] r;
      n_errors = 0; checks = 0; seed = 32'h53c91094;
      resetn_in = 1'b0; dec_valid_in = 1'b0; op_class_in = OAG_NONE; sub_bank_in = 1'b0;
      op_byte0_in = 8'h00; op_byte1_in = 8'h00; op_byte2_in = 8'h00;
      bank_select_hi_in = 1'b0; bank_select_lo_in = 1'b0; bank_wr_in = 1'b0;
      bank_wr_prefixed_in = 1'b0; bank_data_in = 4'h0; sp_wr_in = 1'b0; sp_data_in = 16'h0000;
      reg_wr_in = 1'b0; reg_wr_addr_in = 5'h00; reg_wr_data_in = 8'h00;
      do_reset();
      $display("test reset done");
      // fill every bank so pair reads are defined
      for (int i = 0; i < 32; i++) begin
         r = rnd();
         wr(0, {8'h00, r[7:0]}, 5'(i));
      end
      $display("test register fill done");
      decode(OAG_REG8, 8'hd2, 8'h00, 8'h00, 1'b0);
      decode(OAG_REG16, 8'h46, 8'h00, 8'h00, 1'b0);
      decode(OAG_REG1, 8'h01, 8'h00, 8'h00, 1'b0);
      for (int c = 1; c < 5; c++) decode(oag_class_t'(5'(c)), 8'h00, 8'h00, 8'h00, 1'b0);
      decode(OAG_IMM8, 8'ha8, 8'h77, 8'h55, 1'b0);
      decode(OAG_IMM16, 8'h00, 8'h34, 8'h12, 1'b0);
      decode(OAG_SADDR, 8'h00, 8'h00, 8'h00, 1'b0);
      decode(OAG_SADDR, 8'h00, 8'h1f, 8'h00, 1'b0);
      decode(OAG_SADDR, 8'h00, 8'h20, 8'h00, 1'b0);
      decode(OAG_SADDRP, 8'h00, 8'hff, 8'h00, 1'b0);
      decode(OAG_SADDRP, 8'h00, 8'h1e, 8'h00, 1'b0);
      decode(OAG_SADDRP, 8'h00, 8'h1f, 8'h00, 1'b0);
      decode(OAG_SFR, 8'h00, 8'hff, 8'h00, 1'b0);
      decode(OAG_SFRP, 8'h00, 8'h20, 8'h00, 1'b0);
      $display("test corner decodes done");
      wr(1, 16'h0003, 5'h00);
      wr(1, 16'h0009, 5'h01);
      decode(OAG_DIRECT, 8'h09, 8'h00, 8'hfe, 1'b0);
      decode(OAG_DIRECT, 8'h09, 8'h00, 8'hfe, 1'b1);
      decode(OAG_SADDR, 8'h00, 8'h40, 8'h00, 1'b1);
      wr(1, 16'h0000, 5'h00);
      decode(OAG_DIRECT, 8'h09, 8'h10, 8'hff, 1'b0);
      $display("test bank registers done");
      wr(2, 16'h0100, 5'h00);
      decode(OAG_STACK, 8'h00, 8'h00, 8'h00, 1'b0);
      decode(OAG_STACK, 8'h00, 8'h00, 8'h00, 1'b0);
      decode(OAG_UNSTACK, 8'h00, 8'h00, 8'h00, 1'b0);
      $display("test stack done");
      for (int n = 0; n < 400; n++) begin
         r = rnd();
         if (r[31:29] == 3'h0) wr(int'(r[28:27] % 2'h3), r[15:0], r[20:16]);
         r = rnd();
         decode(r[31] ? OAG_DIRECT : oag_class_t'({1'b0, r[27:24]}), r[7:0], r[15:8], r[23:16], r[30]);
      end
      $display("test random decodes done");
      do_reset();
      $display("test second reset done");
      print_verdict();
   end
endmodule
